// File: common/irq_enable_pkg.sv
// Purpose: Constants for the interrupt enable clear/set register pair
// Assumes: Word registers on a plain address/strobe port
// Notes:   Offsets are byte addresses

`default_nettype none

package irq_enable_pkg;

    // Bus geometry
    localparam int          ADDR_W = 8;
    localparam int          DATA_W = 32;

    // Register offsets
    localparam logic [7:0]  OFS_ENABLE_CLR = 8'h00;
    localparam logic [7:0]  OFS_ENABLE_SET = 8'h04;

    // Implemented enable bits and reset value
    localparam logic [31:0] IE_IMPL_MASK = 32'h0003_8fff;
    localparam logic [31:0] IE_RESET     = 32'h0000_0000;

    // Enable bit positions
    localparam int BIT_XTAL_READY     = 0;
    localparam int BIT_XTAL32K_READY  = 1;
    localparam int BIT_RC32K_READY    = 2;
    localparam int BIT_RC8M_READY     = 3;
    localparam int BIT_FLL_READY      = 4;
    localparam int BIT_FLL_OOB        = 5;
    localparam int BIT_FLL_FINE_LOCK  = 6;
    localparam int BIT_FLL_COARSE     = 7;
    localparam int BIT_FLL_REF_STOP   = 8;
    localparam int BIT_BOD_READY      = 9;
    localparam int BIT_BOD_DETECT     = 10;
    localparam int BIT_BOD_SYNC_READY = 11;
    localparam int BIT_PLL_LOCK_GAIN  = 15;
    localparam int BIT_PLL_LOCK_LOST  = 16;
    localparam int BIT_PLL_LOCK_TO    = 17;

endpackage : irq_enable_pkg

`default_nettype wire

// File: design/irq_enable_ctrl.sv
// Purpose: Interrupt enable state of the clock and supply controller,
//          reached through a write-one-to-clear and a write-one-to-set word
// Assumes: Flags and write protection come from logic on core_clk_i
// Notes:   Read data stand only in the cycle after the read strobe
//
// The address-and-strobe port was chosen for this implementation.

`default_nettype none

module irq_enable_ctrl
    import irq_enable_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    input  wire logic              wr_en_i,
    input  wire logic              rd_en_i,
    output logic      [DATA_W-1:0] rd_data_o,
    // Write protection
    input  wire logic              wr_prot_i,
    output logic                   wr_blocked_o,
    // Interrupt sources
    input  wire logic [DATA_W-1:0] irq_flag_i,
    output logic      [DATA_W-1:0] irq_src_o,
    output logic                   irq_req_o,
    output logic      [DATA_W-1:0] enable_o
);

    logic [DATA_W-1:0] ie_r;
    logic [DATA_W-1:0] ie_nxt;
    logic [DATA_W-1:0] rd_data_r;
    logic [DATA_W-1:0] rd_data_nxt;
    logic              blocked_r;
    logic              blocked_nxt;
    logic              wr_ok;
    logic              hit_clr;
    logic              hit_set;
    logic [DATA_W-1:0] clr_mask;
    logic [DATA_W-1:0] set_mask;

    assign hit_clr = (addr_i == OFS_ENABLE_CLR);
    assign hit_set = (addr_i == OFS_ENABLE_SET);
    assign wr_ok   = wr_en_i && !wr_prot_i;

    // Only ones in implemented positions act
    always_comb begin
        clr_mask = '0;
        set_mask = '0;
        if (wr_ok && hit_clr) begin
            clr_mask = wr_data_i & IE_IMPL_MASK;
        end
        if (wr_ok && hit_set) begin
            set_mask = wr_data_i & IE_IMPL_MASK;
        end
    end

    // Enable state: clear applied after set so clear wins
    always_comb begin
        ie_nxt = (ie_r | set_mask) & ~clr_mask;
        ie_nxt = ie_nxt & IE_IMPL_MASK;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ie_r <= IE_RESET;
        end else begin
            ie_r <= ie_nxt;
        end
    end

    // Read path: both offsets show the enables
    always_comb begin
        rd_data_nxt = '0;
        if (rd_en_i && (hit_clr || hit_set)) begin
            rd_data_nxt = ie_r & IE_IMPL_MASK;
        end
    end

    // Refused-write indication
    always_comb begin
        blocked_nxt = wr_en_i && wr_prot_i &&
                      (hit_clr || hit_set);
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rd_data_r <= '0;
            blocked_r <= 1'b0;
        end else begin
            rd_data_r <= rd_data_nxt;
            blocked_r <= blocked_nxt;
        end
    end

    // Interrupt gating
    assign irq_src_o    = ie_r & irq_flag_i;
    assign irq_req_o    = |irq_src_o;
    assign enable_o     = ie_r;
    assign rd_data_o    = rd_data_r;
    assign wr_blocked_o = blocked_r;

    // Checks
    default clocking cb @(posedge core_clk_i);
    endclocking

    default disable iff (!rst_n_i);

    sequence s_clr_wr(int b);
        wr_ok && hit_clr && wr_data_i[b];
    endsequence

    sequence s_set_wr(int b);
        wr_ok && hit_set && wr_data_i[b] && !(hit_clr);
    endsequence

    property p_clr(int b);
        s_clr_wr(b) |=> !ie_r[b] && !irq_src_o[b];
    endproperty

    property p_set(int b);
        s_set_wr(b) |=> ie_r[b];
    endproperty

    AST_KEEP_ZERO:
        assert property (wr_ok && hit_clr |=>
            ((ie_r & ~$past(wr_data_i)) ==
             ($past(ie_r) & ~$past(wr_data_i))))
        else $error("Zero written to clear changed an enable");

    AST_CLR_PLL_TO:
        assert property (p_clr(BIT_PLL_LOCK_TO))
        else $error("PLL lock timeout enable not cleared");

    AST_CLR_PLL_LOST:
        assert property (p_clr(BIT_PLL_LOCK_LOST))
        else $error("PLL lock lost enable not cleared");

    AST_CLR_PLL_GAIN:
        assert property (p_clr(BIT_PLL_LOCK_GAIN))
        else $error("PLL lock gained enable not cleared");

    AST_CLR_BOD_SYNC:
        assert property (p_clr(BIT_BOD_SYNC_READY))
        else $error("Brownout sync ready enable not cleared");

    AST_CLR_BOD_DET:
        assert property (p_clr(BIT_BOD_DETECT))
        else $error("Brownout detect enable not cleared");

    AST_CLR_BOD_RDY:
        assert property (p_clr(BIT_BOD_READY))
        else $error("Brownout ready enable not cleared");

    AST_CLR_FLL_REF:
        assert property (p_clr(BIT_FLL_REF_STOP))
        else $error("FLL reference stopped enable not cleared");

    AST_CLR_FLL_CRS:
        assert property (p_clr(BIT_FLL_COARSE))
        else $error("FLL coarse lock enable not cleared");

    AST_CLR_FLL_FINE:
        assert property (p_clr(BIT_FLL_FINE_LOCK))
        else $error("FLL fine lock enable not cleared");

    AST_CLR_FLL_OOB:
        assert property (p_clr(BIT_FLL_OOB))
        else $error("FLL out of bounds enable not cleared");

    AST_CLR_FLL_RDY:
        assert property (p_clr(BIT_FLL_READY))
        else $error("FLL ready enable not cleared");

    AST_CLR_RC8M:
        assert property (p_clr(BIT_RC8M_READY))
        else $error("8 MHz oscillator ready enable not cleared");

    AST_CLR_RC32K:
        assert property (p_clr(BIT_RC32K_READY))
        else $error("32 kHz oscillator ready enable not cleared");

    AST_CLR_X32K:
        assert property (p_clr(BIT_XTAL32K_READY))
        else $error("32 kHz crystal ready enable not cleared");

    AST_CLR_XTAL:
        assert property (p_clr(BIT_XTAL_READY))
        else $error("Crystal oscillator ready enable not cleared");

    AST_IRQ_ON:
        assert property (s_set_wr(BIT_FLL_READY) ##1
                         irq_flag_i[BIT_FLL_READY] |-> irq_req_o)
        else $error("Enabled flagged source did not request");

    AST_IRQ_OFF:
        assert property (s_clr_wr(BIT_BOD_DETECT) ##1
                         !(|(irq_flag_i & ~(32'h1 << BIT_BOD_DETECT)))
                         |-> !irq_req_o)
        else $error("Disabled source still requests");

    AST_RESET_ZERO:
        assert property (disable iff (1'b0)
                         !rst_n_i |=> ie_r == IE_RESET && !irq_req_o)
        else $error("Enables not zero after reset");

    AST_PROT_HOLD:
        assert property (wr_en_i && wr_prot_i |=>
                         $stable(ie_r) && wr_blocked_o == $past(hit_clr
                         || hit_set))
        else $error("Protected write altered enables");

    AST_SET_SHARED:
        assert property (p_set(BIT_PLL_LOCK_TO))
        else $error("Set register did not enable source");

    AST_READ_BACK:
        assert property (rd_en_i && (hit_clr || hit_set) |=>
                         rd_data_o == $past(ie_r))
        else $error("Read data differ from enables");

    AST_RESERVED_ZERO:
        assert property (wr_en_i |=> ##[0:1]
                         (ie_r & ~IE_IMPL_MASK) == '0 &&
                         (rd_data_o & ~IE_IMPL_MASK) == '0)
        else $error("Unimplemented bit became visible");

    // Write-path checks
    AST_SET_KEEP_ZERO:
        assert property (wr_ok && hit_set |=>
            ((ie_r & ~$past(wr_data_i)) ==
             ($past(ie_r) & ~$past(wr_data_i))))
        else $error("Zero written to set changed an enable");

    AST_CLR_ONLY_DOWN:
        assert property (wr_ok && hit_clr |=>
                         (ie_r & ~$past(ie_r)) == '0)
        else $error("Clear write raised an enable");

    AST_SET_ONLY_UP:
        assert property (wr_ok && hit_set |=>
                         ($past(ie_r) & ~ie_r) == '0)
        else $error("Set write lowered an enable");

    AST_IDLE_HOLD:
        assert property (!wr_ok |=> $stable(ie_r))
        else $error("Enables changed without an accepted write");

    AST_UNMAPPED_HOLD:
        assert property (wr_en_i && !(hit_clr || hit_set) |=>
                         $stable(ie_r))
        else $error("Write to an unmapped offset changed enables");

    // Read path and refusal checks
    AST_RD_IDLE:
        assert property (!(rd_en_i && (hit_clr || hit_set)) |=>
                         rd_data_o == '0)
        else $error("Read data stood outside their cycle");

    AST_RD_UNMAPPED:
        assert property (rd_en_i && !(hit_clr || hit_set) |=>
                         rd_data_o == '0)
        else $error("Unmapped read returned data");

    AST_BLK_ONLY_PROT:
        assert property (!(wr_en_i && wr_prot_i) |=> !wr_blocked_o)
        else $error("Blocked flag without a protected write");

    AST_BLK_CAUSE:
        assert property (wr_blocked_o |->
                         $past(wr_en_i && wr_prot_i && (hit_clr || hit_set)))
        else $error("Blocked flag without a refused register write");

    AST_RESET_OUTS:
        assert property (disable iff (1'b0)
                         !rst_n_i |=> rd_data_o == '0 && !wr_blocked_o)
        else $error("Read data or blocked flag not idle after reset");

    // Interrupt output checks
    AST_REQ_ANY:
        assert property ((enable_o & irq_flag_i) != '0 |-> irq_req_o)
        else $error("Enabled flagged source left without request");

    AST_REQ_NONE:
        assert property ((enable_o & irq_flag_i) == '0 |-> !irq_req_o)
        else $error("Request without an enabled flagged source");

    AST_FLAG_IDLE:
        assert property (irq_flag_i == '0 |-> !irq_req_o)
        else $error("Request with no flag raised");

    AST_SRC_RESERVED:
        assert property ((irq_src_o & ~IE_IMPL_MASK) == '0)
        else $error("Unimplemented position raised a request");

    // Per-position checks
    for (genvar g = 0; g < DATA_W; g++) begin : g_pos_chk
        if (IE_IMPL_MASK[g]) begin : g_impl
            AST_SET_BIT:
                assert property (@(posedge core_clk_i)
                    disable iff (!rst_n_i)
                    wr_ok && hit_set && wr_data_i[g] |=> ie_r[g])
                else $error("Set write did not enable its source");

            AST_REQ_BIT:
                assert property (@(posedge core_clk_i)
                    disable iff (!rst_n_i)
                    ie_r[g] && irq_flag_i[g] |-> irq_src_o[g] && irq_req_o)
                else $error("Enabled flagged position did not request");

            AST_MASK_BIT:
                assert property (@(posedge core_clk_i)
                    disable iff (!rst_n_i)
                    !ie_r[g] |-> !irq_src_o[g])
                else $error("Disabled position requested");
        end else begin : g_rsvd
            AST_RSVD_BIT:
                assert property (@(posedge core_clk_i)
                    disable iff (!rst_n_i)
                    !ie_r[g] && !rd_data_o[g] && !irq_src_o[g])
                else $error("Unimplemented position became active");
        end
    end

endmodule // irq_enable_ctrl

`default_nettype wire

// File: test/clock_sysctl_irq_enable_clear_bench.sv
// Purpose: Self-checking bench for the interrupt enable clear/set pair
// Assumes: Strobes raised by non-blocking assignment 1 ns after a rising edge, dropped at the next one
// Notes:   Samples outputs 1 ns after the edge that updates them

`default_nettype none

module clock_sysctl_irq_enable_clear_bench
    import irq_enable_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk;
    logic              rst_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] rd_data;
    logic              wr_prot;
    logic              wr_blocked;
    logic [DATA_W-1:0] irq_flag;
    logic [DATA_W-1:0] irq_src;
    logic              irq_req;
    logic [DATA_W-1:0] enable;
    int                n_mismatch;
    int                comparisons;
    int                cycles;
    logic [DATA_W-1:0] one_bit;

    irq_enable_ctrl i_irq_enable_ctrl (
        .core_clk_i   (core_clk),
        .rst_n_i      (rst_n),
        .addr_i       (addr),
        .wr_data_i    (wr_data),
        .wr_en_i      (wr_en),
        .rd_en_i      (rd_en),
        .rd_data_o    (rd_data),
        .wr_prot_i    (wr_prot),
        .wr_blocked_o (wr_blocked),
        .irq_flag_i   (irq_flag),
        .irq_src_o    (irq_src),
        .irq_req_o    (irq_req),
        .enable_o     (enable)
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (n_mismatch == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Clear of one position, compared the same way for all, under a label named for that position
    task automatic chk_clr(input int b, input logic [31:0] exp);
        case (b)
            BIT_PLL_LOCK_TO:    chk("clr_lock_to", enable, exp);
            BIT_PLL_LOCK_LOST:  chk("clr_lock_lost", enable, exp);
            BIT_PLL_LOCK_GAIN:  chk("clr_lock_gain", enable, exp);
            BIT_BOD_SYNC_READY: chk("clr_bod_sync", enable, exp);
            BIT_BOD_DETECT:     chk("clr_bod_det", enable, exp);
            BIT_BOD_READY:      chk("clr_bod_rdy", enable, exp);
            BIT_FLL_REF_STOP:   chk("clr_fll_ref", enable, exp);
            BIT_FLL_COARSE:     chk("clr_fll_crs", enable, exp);
            BIT_FLL_FINE_LOCK:  chk("clr_fll_fine", enable, exp);
            BIT_FLL_OOB:        chk("clr_fll_oob", enable, exp);
            BIT_FLL_READY:      chk("clr_fll_rdy", enable, exp);
            BIT_RC8M_READY:     chk("clr_rc8m", enable, exp);
            BIT_RC32K_READY:    chk("clr_rc32k", enable, exp);
            BIT_XTAL32K_READY:  chk("clr_x32k", enable, exp);
            default:            chk("clr_xtal", enable, exp);
        endcase
    endtask

    // Strobe drops at the sampling edge; a next call raises it 1 ns on
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        rd_en   <= 1'b0;
        @(posedge core_clk);
        wr_en   <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string nm);
        addr  <= a;
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk(nm, rd_data, exp);
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial begin
        rst_n = 1'b0;
        addr = 8'h00;
        wr_data = 32'h0000_0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wr_prot = 1'b0;
        irq_flag = 32'h0000_0000;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        chk("enable_rst", enable, IE_RESET);
        rd(OFS_ENABLE_CLR, IE_RESET, "clr_rst");
        rd(OFS_ENABLE_SET, IE_RESET, "set_rst");
        wr(OFS_ENABLE_SET, 32'hffff_ffff);
        chk("enable_all", enable, IE_IMPL_MASK);
        rd(OFS_ENABLE_CLR, IE_IMPL_MASK, "clr_read");
        @(posedge core_clk);
        #1;
        chk("rd_after", rd_data, 32'h0000_0000);
        wr(OFS_ENABLE_CLR, 32'h0000_0000);
        chk("clr_zero", enable, IE_IMPL_MASK);
        wr(OFS_ENABLE_CLR, ~IE_IMPL_MASK);
        chk("clr_unimpl", enable, IE_IMPL_MASK);
        for (int b = 0; b < 32; b++) begin
            if (IE_IMPL_MASK[b]) begin
                one_bit = 32'h0000_0001 << b;
                irq_flag <= one_bit;
                wr(OFS_ENABLE_SET, 32'hffff_ffff);
                chk("req_on", {31'h0, irq_req}, 32'h1);
                chk("src_on", irq_src, one_bit);
                wr(OFS_ENABLE_CLR, one_bit);
                // Each implemented bit clears only itself
                chk_clr(b, IE_IMPL_MASK & ~one_bit);
                chk("req_off", {31'h0, irq_req}, 32'h0);
                chk("src_off", irq_src, 32'h0000_0000);
            end
        end
        irq_flag <= 32'hffff_ffff;
        wr(OFS_ENABLE_SET, IE_IMPL_MASK);
        wr_prot <= 1'b1;
        wr(OFS_ENABLE_CLR, 32'hffff_ffff);
        chk("prot_en", enable, IE_IMPL_MASK);
        chk("prot_blk", {31'h0, wr_blocked}, 32'h1);
        wr_prot <= 1'b0;
        @(posedge core_clk);
        #1;
        chk("blk_end", {31'h0, wr_blocked}, 32'h0);
        wr(OFS_ENABLE_CLR, 32'hffff_ffff);
        chk("clr_all", enable, 32'h0000_0000);
        chk("req_none", {31'h0, irq_req}, 32'h0);
        wr_prot <= 1'b1;
        wr(OFS_ENABLE_SET, 32'hffff_ffff);
        chk("prot_set", enable, 32'h0000_0000);
        chk("prot_set_blk", {31'h0, wr_blocked}, 32'h1);
        wr(8'h08, 32'hffff_ffff);
        chk("prot_unmapped", {31'h0, wr_blocked}, 32'h0);
        wr_prot <= 1'b0;
        rd(OFS_ENABLE_SET, 32'h0000_0000, "prot_rd");
        wr(8'h08, 32'hffff_ffff);
        chk("unmapped_wr", enable, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000, "unmapped_rd");
        // Reset in mid-run, with a read in flight
        wr(OFS_ENABLE_SET, IE_IMPL_MASK);
        rst_n <= 1'b0;
        rd(OFS_ENABLE_CLR, IE_RESET, "mid_rst_rd");
        chk("mid_rst_en", enable, IE_RESET);
        chk("mid_rst_req", {31'h0, irq_req}, 32'h0);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        wr(OFS_ENABLE_SET, 32'h0002_0000);
        chk("post_rst_en", enable, 32'h0002_0000);
        chk("post_rst_src", irq_src, 32'h0002_0000);
        give_verdict();
    end

endmodule // clock_sysctl_irq_enable_clear_bench

`default_nettype wire
